// File: test/asr_line_model.sv
// Remote serial transmitter model that drives the receive line
module asr_line_model #(
   parameter int BIT_CLKS = 64   // Clocks per bit at divisor zero, low speed
) (
   input  wire logic clock,   // System clock
   output logic      rxLine   // Serial line, idle high
);
   timeunit 1ns;
   timeprecision 1ns;
   int bitClks = BIT_CLKS;   // Clocks per bit, set by the bench for other rates
   // Line rests high between frames
   initial rxLine = 1'b1;
   // plain digital levels
   // One frame: start, data LSB first, stop, then one idle bit time
   task automatic send(input logic [8:0] d, input int nb, input logic stopBit);
      @(posedge clock);
      for (int i = 0; i <= nb + 2; i++) begin
         rxLine <= (i == 0) ? 1'b0 : (i == nb + 1) ? stopBit : (i > nb) ? 1'b1 : d[i - 1];
         repeat (bitClks) @(posedge clock);
      end
   endtask
   // Low pulse shorter than half a bit, then a quiet line
   task automatic pulse(input int lowClks);
      @(posedge clock);
      rxLine <= 1'b0;
      repeat (lowClks) @(posedge clock);
      rxLine <= 1'b1;
      repeat (12 * bitClks) @(posedge clock);
   endtask
endmodule

// File: test/asr_receiver_tb_top.sv
// Self-checking bench for the asynchronous serial receiver
module asr_receiver_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock = 1'b0;
   logic        nrst  = 1'b0;
   logic        cyc   = 1'b0;
   logic        stb   = 1'b0;
   logic        we    = 1'b0;
   logic [7:0]  adr   = 8'h00;
   logic [3:0]  sel   = 4'hF;
   logic [31:0] dat   = 32'h00000000;
   logic [31:0] rdo;
   logic        ack;
   logic        irq;
   logic        rxLine;
   logic [7:0]  r;
   int          failures = 0;
   int          comparisons = 0;

   // Clock of 40 ns period
   always #20 clock = ~clock;

   asr_receiver u_dut (.clock(clock), .nrst(nrst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rdo), .ack_o(ack), .rxLine(rxLine),
      .irq(irq));
   asr_line_model u_line (.clock(clock), .rxLine(rxLine));

   // Verdict and end of run
   task automatic close_out;
      $display("failures %0d comparisons %0d", failures, comparisons);
      if (failures == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Compare one byte
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         $display("unexpected %s expected %h seen %h", nm, e, g);
         failures++;
      end
   endtask

   // Classic Wishbone single cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= {24'h000000, d};
      do begin
         @(posedge clock);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) begin
         failures++;
         close_out();
      end
      r = rdo[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clock);
   endtask

   // Read a register and compare
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      wb(1'b0, a, 8'h00);
      chk($sformatf("reg %h", a), e, r);
   endtask

   // Reset values and an unmapped place
   task automatic t_reset;
      rc(8'h00, 8'h00);
      rc(8'h10, 8'h02);
      rc(8'h28, 8'h00);
   endtask

   // Pending character, gated interrupt, event clear
   task automatic t_basic;
      wb(1'b1, 8'h00, 8'h90);
      wb(1'b1, 8'h18, 8'h03);
      u_line.send(9'h0A5, 8, 1'b1);
      chk("irq", 8'h00, {7'h00, irq});
      wb(1'b1, 8'h18, 8'h07);
      repeat (2) @(posedge clock);
      chk("irq", 8'h01, {7'h00, irq});
      rc(8'h1C, 8'h01);
      rc(8'h00, 8'h90);
      rc(8'h04, 8'hA5);
      rc(8'h04, 8'h00);
      wb(1'b1, 8'h24, 8'h01);
      repeat (2) @(posedge clock);
      chk("irq", 8'h01, {7'h00, irq});
      wb(1'b1, 8'h20, 8'h01);
      repeat (2) @(posedge clock);
      chk("irq", 8'h00, {7'h00, irq});
      wb(1'b1, 8'h24, 8'h00);
   endtask

   // Framing error, then overrun and its clearing
   task automatic t_errors;
      u_line.send(9'h03C, 8, 1'b0);
      rc(8'h00, 8'h94);
      rc(8'h04, 8'h3C);
      for (int i = 1; i <= 3; i++) u_line.send(9'(i * 17), 8, 1'b1);
      rc(8'h00, 8'h92);
      rc(8'h04, 8'h11);
      u_line.send(9'h044, 8, 1'b1);
      rc(8'h00, 8'h92);
      wb(1'b1, 8'h00, 8'h80);
      rc(8'h00, 8'h80);
      rc(8'h04, 8'h22);
      rc(8'h04, 8'h00);
   endtask

   // Nine-bit characters with address filtering
   task automatic t_addr;
      wb(1'b1, 8'h00, 8'hD8);
      u_line.send(9'h033, 9, 1'b1);
      u_line.send(9'h144, 9, 1'b1);
      rc(8'h00, 8'hD9);
      rc(8'h04, 8'h44);
      rc(8'h04, 8'h00);
      rc(8'h00, 8'hD9);
      wb(1'b1, 8'h00, 8'hD0);
      u_line.send(9'h055, 9, 1'b1);
      rc(8'h00, 8'hD0);
      rc(8'h04, 8'h55);
   endtask

   // Mode select, receive enable and port enable
   task automatic t_off;
      wb(1'b1, 8'h00, 8'h90);
      wb(1'b1, 8'h10, 8'h10);
      u_line.send(9'h066, 8, 1'b1);
      wb(1'b1, 8'h10, 8'h00);
      rc(8'h04, 8'h00);
      wb(1'b1, 8'h00, 8'h80);
      u_line.send(9'h069, 8, 1'b1);
      rc(8'h04, 8'h00);
      wb(1'b1, 8'h00, 8'h90);
      u_line.send(9'h077, 8, 1'b1);
      wb(1'b1, 8'h00, 8'h10);
      rc(8'h04, 8'h00);
      rc(8'h00, 8'h10);
   endtask

   // Ignored byte lane, divisor pair and speed selects at 16 clocks per bit
   task automatic t_rate;
      sel <= 4'h0;
      wb(1'b1, 8'h0C, 8'h01);
      sel <= 4'hF;
      rc(8'h0C, 8'h00);
      wb(1'b1, 8'h0C, 8'h01);
      wb(1'b1, 8'h10, 8'h04);
      wb(1'b1, 8'h00, 8'h90);
      u_line.bitClks = 16;
      u_line.send(9'h0C3, 8, 1'b1);
      rc(8'h04, 8'hC3);
      wb(1'b1, 8'h0C, 8'h00);
      wb(1'b1, 8'h08, 8'h03);
      wb(1'b1, 8'h14, 8'h08);
      rc(8'h14, 8'h48);
      u_line.send(9'h03A, 8, 1'b1);
      rc(8'h04, 8'h3A);
   endtask

   // Auto-baud measures one low bit and loads the divisor
   task automatic t_abd;
      wb(1'b1, 8'h10, 8'h00);
      wb(1'b1, 8'h14, 8'h00);
      wb(1'b1, 8'h08, 8'h2A);
      wb(1'b1, 8'h14, 8'h01);
      rc(8'h14, 8'h01);
      u_line.bitClks = 64;
      u_line.send(9'h0FF, 8, 1'b1);
      rc(8'h08, 8'h00);
      rc(8'h14, 8'h40);
   endtask

   // Short low pulse is dropped at the start check
   task automatic t_glitch;
      u_line.pulse(16);
      rc(8'h04, 8'h00);
      u_line.send(9'h081, 8, 1'b1);
      rc(8'h04, 8'h81);
   endtask

   // Main sequence
   initial begin
      repeat (8) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
      t_reset();
      t_basic();
      t_errors();
      t_addr();
      t_off();
      t_rate();
      t_abd();
      t_glitch();
      close_out();
   end
endmodule

// File: verilog/asr_pkg.sv
// Package with register map, field positions, reset values and states of the serial receiver
package asr_pkg;

   // ****************************************
   // Register byte offsets
   // ****************************************
   localparam logic [7:0] OFF_RX_STATUS   = 8'h00;
   localparam logic [7:0] OFF_RX_DATA     = 8'h04;
   localparam logic [7:0] OFF_DIV_LOW     = 8'h08;
   localparam logic [7:0] OFF_DIV_HIGH    = 8'h0C;
   localparam logic [7:0] OFF_TX_STATUS   = 8'h10;
   localparam logic [7:0] OFF_BAUD_CTRL   = 8'h14;
   localparam logic [7:0] OFF_IRQ_CTRL    = 8'h18;
   localparam logic [7:0] OFF_EVT_STATUS  = 8'h1C;
   localparam logic [7:0] OFF_EVT_CLEAR   = 8'h20;
   localparam logic [7:0] OFF_EVT_ENABLE  = 8'h24;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int RS_PORT_EN    = 7;   // serial_port_enable
   localparam int RS_NINE_BIT   = 6;   // nine_bit_receive_select
   localparam int RS_CONT_EN    = 4;   // continuous_receive_enable
   localparam int RS_ADDR_DET   = 3;   // address_detect_enable
   localparam int RS_FRAME_ERR  = 2;
   localparam int RS_OVERRUN    = 1;
   localparam int RS_NINTH_BIT  = 0;
   localparam int TS_MODE_SEL   = 4;   // link mode select, set = non-asynchronous
   localparam int TS_HIGH_SPEED = 2;   // high_speed_baud_select
   localparam int TS_SHIFT_IDLE = 1;   // transmit shifter empty, always reads one here
   localparam int BC_ABD_OVF    = 7;
   localparam int BC_RX_IDLE    = 6;
   localparam int BC_WIDE_DIV   = 3;   // wide_divider_select
   localparam int BC_ABD_EN     = 0;
   localparam int IC_RX_IRQ_EN  = 0;   // receive_irq_enable
   localparam int IC_PERIPH_EN  = 1;   // peripheral_irq_enable
   localparam int IC_GLOBAL_EN  = 2;   // global_irq_enable
   localparam int EV_RECEIVED   = 0;
   localparam int EV_FRAME      = 1;
   localparam int EV_OVERRUN    = 2;

   // ****************************************
   // Reset values and masks
   // ****************************************
   localparam logic [7:0]  RST_RX_STATUS = 8'h00;
   localparam logic [7:0]  RST_TX_STATUS = 8'h02;
   localparam logic [7:0]  RST_BAUD_CTRL = 8'h00;
   localparam logic [15:0] RST_DIVISOR   = 16'h0000;
   localparam logic [7:0]  MSK_RX_STATUS = 8'hF8;   // Writable bits of receive status/control
   localparam logic [7:0]  MSK_BAUD_CTRL = 8'h1B;   // Writable bits of baud control

   // ****************************************
   // Timing counts in sample ticks, and buffer depth
   // ****************************************
   localparam logic [22:0] TICK_STEP    = 23'h000010; // Sixteen samples per bit
   localparam logic [3:0]  SAMPLE_FIRST = 4'h7;       // First of three majority samples
   localparam logic [3:0]  SAMPLE_MID   = 4'h8;
   localparam logic [3:0]  BIT_CENTRE   = 4'h9;       // Decision point of each bit
   localparam logic [1:0]  FIFO_DEPTH   = 2'h2;

   typedef enum logic [2:0] {
      RS_IDLE  = 3'b000,
      RS_START = 3'b001,
      RS_DATA  = 3'b010,
      RS_STOP  = 3'b011,
      RS_ABDW  = 3'b100,
      RS_ABDM  = 3'b101
   } asr_state_t;

endpackage

// File: verilog/asr_receiver.sv
// Asynchronous serial receiver with two-entry buffer, Wishbone registers and interrupt
//
// The Wishbone register port and the address map were decided locally.
module asr_receiver (
   input  wire logic        clock,   // System clock, 25 MHz
   input  wire logic        nrst,    // Asynchronous reset, active low
   input  wire logic        cyc_i,   // Wishbone cycle
   input  wire logic        stb_i,   // Wishbone strobe
   input  wire logic        we_i,    // Wishbone write enable
   input  wire logic [7:0]  adr_i,   // Wishbone byte address
   input  wire logic [3:0]  sel_i,   // Wishbone byte selects
   input  wire logic [31:0] dat_i,   // Wishbone write data
   output logic      [31:0] dat_o,   // Wishbone read data
   output logic             ack_o,   // Wishbone acknowledge
   input  wire logic        rxLine,  // Serial receive line
   output logic             irq      // Level interrupt
);

   // ****************************************
   // Declarations
   // ****************************************
   asr_pkg::asr_state_t stateQ;
   logic [7:0]  rxCtrlQ;
   logic [7:0]  txCtrlQ;
   logic [7:0]  baudCtrlQ;
   logic        abdOvfQ;
   logic [15:0] divQ;
   logic [2:0]  irqCtrlQ;
   logic [2:0]  evtQ;
   logic [2:0]  evtEnQ;
   logic        oerrQ;
   logic [22:0] accQ;
   logic [3:0]  tickQ;
   logic [3:0]  bitQ;
   logic [8:0]  shiftQ;
   logic [1:0]  smpQ;
   logic        rxPrevQ;
   logic [22:0] abdCntQ;
   logic [9:0]  memQ [2];
   logic        rdPtrQ;
   logic        wrPtrQ;
   logic [1:0]  cntQ;
   logic        busAcc;
   logic        busWr;
   logic        busRd;
   logic [7:0]  regAddr;
   logic        portEn;
   logic        nineBit;
   logic        contEn;
   logic        addrDet;
   logic        rxOn;
   logic        abdOn;
   logic [2:0]  rateShift;
   logic [22:0] limit;
   logic [22:0] accSum;
   logic        tick;
   logic        atCentre;
   logic        maj;
   logic        fallEdge;
   logic        charDone;
   logic        addrDrop;
   logic        push;
   logic        ovSet;
   logic        pop;
   logic [9:0]  head;
   logic [9:0]  newEntry;
   logic        abdDone;
   logic        abdOvf;
   logic [22:0] abdDiv;
   logic        rcPending;
   logic        rcIrq;
   logic [7:0]  rdData;

   // ****************************************
   // Bus decode and control bits
   // ****************************************
   // Access is taken on the edge that raises ack
   assign busAcc  = cyc_i & stb_i & ~ack_o;
   assign busWr   = busAcc & we_i & sel_i[0];
   assign busRd   = busAcc & ~we_i;
   assign regAddr = {adr_i[7:2], 2'b00};
   assign portEn  = rxCtrlQ[asr_pkg::RS_PORT_EN];
   assign nineBit = rxCtrlQ[asr_pkg::RS_NINE_BIT];
   assign contEn  = rxCtrlQ[asr_pkg::RS_CONT_EN];
   assign addrDet = rxCtrlQ[asr_pkg::RS_ADDR_DET];
   assign rxOn    = portEn & contEn & ~txCtrlQ[asr_pkg::TS_MODE_SEL];
   assign abdOn   = portEn & baudCtrlQ[asr_pkg::BC_ABD_EN];

   // Acknowledge one cycle after the request, then drop
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= busAcc;
      end
   end

   // Receive status/control writable bits
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rxCtrlQ <= asr_pkg::RST_RX_STATUS;
      end else if (busWr && regAddr == asr_pkg::OFF_RX_STATUS) begin
         rxCtrlQ <= dat_i[7:0] & asr_pkg::MSK_RX_STATUS;
      end
   end

   // Transmit status/control holds the mode and speed selects
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         txCtrlQ <= asr_pkg::RST_TX_STATUS;
      end else if (busWr && regAddr == asr_pkg::OFF_TX_STATUS) begin
         txCtrlQ <= dat_i[7:0];
      end
   end

   // Baud control; auto-baud enable clears itself when done or overflowed
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         baudCtrlQ <= asr_pkg::RST_BAUD_CTRL;
         abdOvfQ   <= 1'b0;
      end else begin
         if (busWr && regAddr == asr_pkg::OFF_BAUD_CTRL) begin
            baudCtrlQ <= dat_i[7:0] & asr_pkg::MSK_BAUD_CTRL;
         end else if (abdDone || abdOvf) begin
            baudCtrlQ[asr_pkg::BC_ABD_EN] <= 1'b0;
         end
         if (abdOvf) begin
            abdOvfQ <= 1'b1;
         end else if (busWr && regAddr == asr_pkg::OFF_BAUD_CTRL
                      && dat_i[asr_pkg::BC_ABD_EN]) begin
            abdOvfQ <= 1'b0;
         end
      end
   end

   // Divisor pair, written by software or by auto-baud
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         divQ <= asr_pkg::RST_DIVISOR;
      end else if (busWr && regAddr == asr_pkg::OFF_DIV_LOW) begin
         divQ[7:0] <= dat_i[7:0];
      end else if (busWr && regAddr == asr_pkg::OFF_DIV_HIGH) begin
         divQ[15:8] <= dat_i[7:0];
      end else if (abdDone) begin
         divQ <= abdDiv[15:0];
      end
   end

   // Interrupt gates and event enables
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         irqCtrlQ <= 3'h0;
         evtEnQ   <= 3'h0;
      end else if (busWr && regAddr == asr_pkg::OFF_IRQ_CTRL) begin
         irqCtrlQ <= dat_i[2:0];
      end else if (busWr && regAddr == asr_pkg::OFF_EVT_ENABLE) begin
         evtEnQ <= dat_i[2:0];
      end
   end

   // ****************************************
   // Baud tick generator
   // ****************************************
   // divisor and speed selects
   always_comb begin
      if (baudCtrlQ[asr_pkg::BC_WIDE_DIV] && txCtrlQ[asr_pkg::TS_HIGH_SPEED]) begin
         rateShift = 3'h2;
      end else if (baudCtrlQ[asr_pkg::BC_WIDE_DIV] || txCtrlQ[asr_pkg::TS_HIGH_SPEED]) begin
         rateShift = 3'h4;
      end else begin
         rateShift = 3'h6;
      end
      if (baudCtrlQ[asr_pkg::BC_WIDE_DIV]) begin
         limit = ({7'h00, divQ} + 23'h000001) << rateShift;
      end else begin
         limit = ({15'h0000, divQ[7:0]} + 23'h000001) << rateShift;
      end
   end

   assign accSum = accQ + asr_pkg::TICK_STEP;
   assign tick   = accSum >= limit;

   // Accumulator restarts on a divisor write so a new rate acts at once
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         accQ <= 23'h000000;
      end else if (!portEn || (busWr && (regAddr == asr_pkg::OFF_DIV_LOW
                                      || regAddr == asr_pkg::OFF_DIV_HIGH))) begin
         accQ <= 23'h000000;
      end else if (tick) begin
         accQ <= accSum - limit;
      end else begin
         accQ <= accSum;
      end
   end

   // ****************************************
   // Data recovery
   // ****************************************
   assign fallEdge = rxPrevQ & ~rxLine;
   assign atCentre = tick && tickQ == asr_pkg::BIT_CENTRE;
   assign maj      = (smpQ[0] & smpQ[1]) | (smpQ[0] & rxLine) | (smpQ[1] & rxLine);

   // Line history and the two early majority samples
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rxPrevQ <= 1'b1;
         smpQ    <= 2'b11;
      end else begin
         rxPrevQ <= rxLine;
         if (tick && tickQ == asr_pkg::SAMPLE_FIRST) begin
            smpQ[0] <= rxLine;
         end
         if (tick && tickQ == asr_pkg::SAMPLE_MID) begin
            smpQ[1] <= rxLine;
         end
      end
   end

   // Receive state machine
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         stateQ <= asr_pkg::RS_IDLE;
         tickQ  <= 4'h0;
         bitQ   <= 4'h0;
         shiftQ <= 9'h000;
      end else if (!portEn || (!rxOn && !abdOn)) begin
         stateQ <= asr_pkg::RS_IDLE;
      end else begin
         if (tick) begin
            tickQ <= tickQ + 4'h1;
         end
         case (stateQ)
            asr_pkg::RS_IDLE: begin
               if (abdOn) begin
                  stateQ <= asr_pkg::RS_ABDW;
               end else if (!oerrQ && fallEdge) begin
                  stateQ <= asr_pkg::RS_START;
                  tickQ  <= 4'h0;
                  bitQ   <= 4'h0;
               end
            end
            asr_pkg::RS_START: begin
               if (atCentre) begin
                  stateQ <= maj ? asr_pkg::RS_IDLE : asr_pkg::RS_DATA;
               end
            end
            asr_pkg::RS_DATA: begin
               if (atCentre) begin
                  shiftQ <= {maj, shiftQ[8:1]};
                  bitQ   <= bitQ + 4'h1;
                  if (bitQ == (nineBit ? 4'h8 : 4'h7)) begin
                     stateQ <= asr_pkg::RS_STOP;
                  end
               end
            end
            asr_pkg::RS_STOP: begin
               if (atCentre) begin
                  stateQ <= asr_pkg::RS_IDLE;
               end
            end
            asr_pkg::RS_ABDW: begin
               if (!abdOn) begin
                  stateQ <= asr_pkg::RS_IDLE;
               end else if (fallEdge) begin
                  stateQ <= asr_pkg::RS_ABDM;
               end
            end
            asr_pkg::RS_ABDM: begin
               if (abdDone || abdOvf) begin
                  stateQ <= asr_pkg::RS_IDLE;
               end
            end
            default: begin
               stateQ <= asr_pkg::RS_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // Auto-baud measurement of one low bit
   // ****************************************
   assign abdDone = stateQ == asr_pkg::RS_ABDM && rxLine;
   assign abdOvf  = stateQ == asr_pkg::RS_ABDM && !rxLine && (&abdCntQ);
   assign abdDiv  = (abdCntQ >> rateShift) - 23'h000001;

   // Counts clocks of the start bit; bit time equals the tick limit
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         abdCntQ <= 23'h000000;
      end else if (stateQ == asr_pkg::RS_ABDM) begin
         abdCntQ <= abdCntQ + 23'h000001;
      end else begin
         abdCntQ <= 23'h000001;
      end
   end

   // ****************************************
   // Character completion and buffer
   // ****************************************
   assign charDone = stateQ == asr_pkg::RS_STOP && atCentre && portEn && rxOn;
   // no filter when detect is off
   assign addrDrop = addrDet & nineBit & ~shiftQ[8];
   assign push     = charDone & ~oerrQ & ~addrDrop & (cntQ != asr_pkg::FIFO_DEPTH);
   assign ovSet    = charDone & ~oerrQ & ~addrDrop & (cntQ == asr_pkg::FIFO_DEPTH);
   // low stop sample is a framing error
   assign newEntry = {~maj, (nineBit ? shiftQ : {1'b0, shiftQ[8:1]})};
   assign pop      = busRd && regAddr == asr_pkg::OFF_RX_DATA && cntQ != 2'h0;
   assign head     = memQ[rdPtrQ];

   // Buffer entries, one store per slot
   for (genvar g = 0; g < 2; g++) begin : gSlot
      always_ff @(posedge clock or negedge nrst) begin
         if (!nrst) begin
            memQ[g] <= 10'h000;
         end else if (push && wrPtrQ == 1'(g)) begin
            memQ[g] <= newEntry;
         end
      end
   end

   // Buffer pointers and fill count
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rdPtrQ <= 1'b0;
         wrPtrQ <= 1'b0;
         cntQ   <= 2'h0;
      end else if (!portEn) begin
         rdPtrQ <= 1'b0;
         wrPtrQ <= 1'b0;
         cntQ   <= 2'h0;
      end else begin
         if (push) begin
            wrPtrQ <= ~wrPtrQ;
         end
         if (pop) begin
            rdPtrQ <= ~rdPtrQ;
         end
         cntQ <= cntQ + {1'b0, push} - {1'b0, pop};
      end
   end

   // Overrun flag; only set while receiving, so set never meets clear
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         oerrQ <= 1'b0;
      end else if (ovSet) begin
         oerrQ <= 1'b1;
      end else if (!portEn || !contEn) begin
         oerrQ <= 1'b0;
      end
   end

   // ****************************************
   // Interrupts
   // ****************************************
   assign rcPending = cntQ != 2'h0;
   // three enables gate the pending flag
   assign rcIrq     = rcPending & irqCtrlQ[asr_pkg::IC_RX_IRQ_EN]
                    & irqCtrlQ[asr_pkg::IC_PERIPH_EN] & irqCtrlQ[asr_pkg::IC_GLOBAL_EN];

   // Sticky events; a new event wins over a clear in the same cycle
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         evtQ <= 3'h0;
      end else begin
         evtQ <= (evtQ & ~((busWr && regAddr == asr_pkg::OFF_EVT_CLEAR) ? dat_i[2:0] : 3'h0))
               | {ovSet, push & newEntry[9], push};
      end
   end

   // Registered interrupt level
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         irq <= 1'b0;
      end else begin
         irq <= rcIrq | (|(evtQ & evtEnQ));
      end
   end

   // ****************************************
   // Read data
   // ****************************************
   always_comb begin
      if (regAddr == asr_pkg::OFF_RX_STATUS) begin
         rdData = {rxCtrlQ[7:3], rcPending & head[9], oerrQ,
                   (addrDet & nineBit) | (rcPending & head[8])};
      end else if (regAddr == asr_pkg::OFF_RX_DATA) begin
         rdData = rcPending ? head[7:0] : 8'h00;
      end else if (regAddr == asr_pkg::OFF_DIV_LOW) begin
         rdData = divQ[7:0];
      end else if (regAddr == asr_pkg::OFF_DIV_HIGH) begin
         rdData = divQ[15:8];
      end else if (regAddr == asr_pkg::OFF_TX_STATUS) begin
         rdData = txCtrlQ | 8'h02;
      end else if (regAddr == asr_pkg::OFF_BAUD_CTRL) begin
         rdData = {abdOvfQ, stateQ == asr_pkg::RS_IDLE, baudCtrlQ[5:0]};
      end else if (regAddr == asr_pkg::OFF_IRQ_CTRL) begin
         rdData = {5'h00, irqCtrlQ};
      end else if (regAddr == asr_pkg::OFF_EVT_STATUS) begin
         rdData = {5'h00, evtQ};
      end else if (regAddr == asr_pkg::OFF_EVT_ENABLE) begin
         rdData = {5'h00, evtEnQ};
      end else begin
         rdData = 8'h00;
      end
   end

   // Read data is registered with the acknowledge
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         dat_o <= 32'h00000000;
      end else if (busRd) begin
         dat_o <= {24'h000000, rdData};
      end else begin
         dat_o <= 32'h00000000;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   sequence sCentreHigh;
      stateQ == asr_pkg::RS_START && atCentre && maj;
   endsequence
   sequence sDataRead;
      pop && !push;
   endsequence

   ack_single_a: assert property (busAcc |=> ack_o ##1 !ack_o)
      else $error("ack not a single pulse");
   push_pending_a: assert property (push |=> rcPending)
      else $error("pending not set after push");
   irq_gate_a: assert property (rcIrq |=> irq)
      else $error("receive interrupt not raised");
   irq_quiet_a: assert property (!(rcPending && (&irqCtrlQ)) && !(|(evtQ & evtEnQ)) |=> !irq)
      else $error("interrupt raised without cause");
   start_abort_a: assert property (sCentreHigh |=> stateQ == asr_pkg::RS_IDLE)
      else $error("false start not aborted");
   overrun_set_a: assert property (ovSet && !pop |=> oerrQ && cntQ == asr_pkg::FIFO_DEPTH)
      else $error("overrun not flagged");
   overrun_clear_a: assert property (!contEn |=> !oerrQ)
      else $error("overrun not cleared");
   port_reset_a: assert property (!portEn |=> cntQ == 2'h0 && !oerrQ)
      else $error("port disable did not reset");
   addr_filter_a: assert property (charDone && addrDrop && !pop |=> $stable(cntQ))
      else $error("address filter let a character in");
   data_read_a: assert property (sDataRead |=> dat_o[7:0] == $past(head[7:0]))
      else $error("wrong data returned");
   ninth_force_a: assert property (busRd && regAddr == asr_pkg::OFF_RX_STATUS
                                   && addrDet && nineBit |=> dat_o[0])
      else $error("ninth bit not forced");
   enable_gate_a: assert property (!rxOn && !abdOn |=> stateQ == asr_pkg::RS_IDLE)
      else $error("receiver ran while disabled");

endmodule
